// ==== src/flash_pin_pkg.sv ====
// Shared constants and types for the serial flash pin interface.
// Assumes a single system clock domain; link pins arrive asynchronously.
`default_nettype none
package flash_pin_pkg;

    // ==========================================
    // Data widths and buffering
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned TX_DEPTH   = 4;

    // ==========================================
    // Positions in the synchronised pin vector
    localparam int unsigned PIN_N      = 6;
    localparam int unsigned PIN_CS     = 0;
    localparam int unsigned PIN_SCK    = 1;
    localparam int unsigned PIN_IO0    = 2;
    localparam int unsigned PIN_IO1    = 3;
    localparam int unsigned PIN_IO2    = 4;
    localparam int unsigned PIN_IO3    = 5;

    // ==========================================
    // Reset values and counts
    // Serial clock resets to its low level so no false edge follows reset
    localparam logic [PIN_N-1:0]  PIN_RST   = 6'h3d;
    localparam logic [3:0]        BITS_BYTE = 4'h8;
    localparam logic [3:0]        CNT_RST   = 4'h0;
    localparam logic [7:0]        FILL_BYTE = 8'h00;

    // ==========================================
    // Lane width chosen by the command decoder
    typedef enum logic [1:0] {
        LANE_SINGLE,
        LANE_DUAL,
        LANE_QUAD
    } laneMode_t;

    // Frame progress
    typedef enum logic [1:0] {
        FRAME_IDLE,
        FRAME_SHIFT,
        FRAME_PAUSE
    } frameState_t;

endpackage

`default_nettype wire

// ==== src/tx_fifo.sv ====
// Small first-in first-out buffer with valid/ready on both sides.
// Assumes DEPTH is a power of two; same clock on both sides.
`timescale 1ns/1ps
`default_nettype none

module tx_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // System
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      rdPtr_reg;
    logic             doWrite;
    logic             doRead;

    // ==========================================
    // Flags and handshakes
    assign outValid = (wrPtr_reg != rdPtr_reg);
    assign inReady  = (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0])
                      || (wrPtr_reg[AW] == rdPtr_reg[AW]);
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;
    assign outData  = store_reg[rdPtr_reg[AW-1:0]];

    // Storage write
    always_ff @(posedge clk)
    begin
        if (doWrite)
        begin
            store_reg[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    // Pointer update
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end
        else
        begin
            if (doWrite)
            begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRead)
            begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== src/serial_flash_pin_interface.sv ====
// Pin-level serial link of a serial flash, device side.
// Assumes a command decoder on clk steers laneMode and driveOut and
// that the bench resolves the two-way pins from the enables.
`timescale 1ns/1ps
`default_nettype none

module serial_flash_pin_interface
    import flash_pin_pkg::*;
(
    // System
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // Link pins
    input  wire logic                     csN,
    input  wire logic                     sck,
    input  wire logic                     io0In,
    output logic                          io0Out,
    output logic                          io0Oe,
    input  wire logic                     io1In,
    output logic                          io1Out,
    output logic                          io1Oe,
    input  wire logic                     quadDataLane2In,
    output logic                          quadDataLane2Out,
    output logic                          quadDataLane2Oe,
    input  wire logic                     quadDataLane3In,
    output logic                          quadDataLane3Out,
    output logic                          quadDataLane3Oe,
    // Configuration
    input  wire logic                     quadEnableBit,
    input  wire logic                     protectModeBitHi,
    input  wire logic                     protectModeBitLo,
    input  wire logic                     selfTimedBusy,
    // Command decoder steering
    input  wire flash_pin_pkg::laneMode_t laneMode,
    input  wire logic                     driveOut,
    // Received stream
    output logic [flash_pin_pkg::BYTE_W-1:0] rxData,
    output logic                          rxValid,
    output logic                          frameStart,
    output logic                          frameEnd,
    // Transmit stream
    input  wire logic [flash_pin_pkg::BYTE_W-1:0] txData,
    input  wire logic                     txValid,
    output logic                          txReady,
    // Status
    output logic                          standby,
    output logic                          pauseActive,
    output logic                          statusWriteBlocked,
    output logic                          frameActive
);

    import flash_pin_pkg::*;

    // ==========================================
    // Declarations
    logic [PIN_N-1:0] pinMeta_reg;
    logic [PIN_N-1:0] pinSync_reg;
    logic             csPrev_reg;
    logic             sckPrev_reg;
    logic             pausePrev_reg;
    frameState_t      state_reg;
    frameState_t      state_next;
    logic [7:0]       rxShift_reg;
    logic [7:0]       rxShift_next;
    logic [3:0]       rxCount_reg;
    logic [3:0]       rxCount_next;
    logic [7:0]       rxData_reg;
    logic             rxValid_reg;
    logic [7:0]       txShift_reg;
    logic [3:0]       txLeft_reg;
    logic [3:0]       io_reg;
    logic             frameStart_reg;
    logic             frameEnd_reg;
    logic             standby_reg;
    logic             blocked_reg;
    logic             csHigh;
    logic             sckLevel;
    logic             pauseLevel;
    logic             csFall;
    logic             csRise;
    logic             sckRise;
    logic             sckFall;
    logic             pauseFall;
    logic             pauseRise;
    logic             live;
    logic             talking;
    logic             rxTake;
    laneMode_t        effMode;
    logic [3:0]       width;
    logic [7:0]       fifoData;
    logic             fifoValid;
    logic             fifoPop;
    logic [7:0]       launchByte;

    // ==========================================
    // Pin synchronisers, two stages each
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pinMeta_reg <= PIN_RST;
            pinSync_reg <= PIN_RST;
        end
        else
        begin
            pinMeta_reg <= {quadDataLane3In, quadDataLane2In, io1In, io0In, sck, csN};
            pinSync_reg <= pinMeta_reg;
        end
    end

    // Previous levels for edge detection
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            csPrev_reg    <= 1'b1;
            sckPrev_reg   <= 1'b0;
            pausePrev_reg <= 1'b1;
        end
        else
        begin
            csPrev_reg    <= pinSync_reg[PIN_CS];
            sckPrev_reg   <= pinSync_reg[PIN_SCK];
            pausePrev_reg <= pinSync_reg[PIN_IO3];
        end
    end

    // ==========================================
    // Edges; either clock idle level works, capture stays on the rise
    assign csHigh     = pinSync_reg[PIN_CS];
    assign sckLevel   = pinSync_reg[PIN_SCK];
    assign pauseLevel = pinSync_reg[PIN_IO3];
    assign csFall     = csPrev_reg && !csHigh;
    assign csRise     = !csPrev_reg && csHigh;
    assign sckRise    = !sckPrev_reg && sckLevel;
    assign sckFall    = sckPrev_reg && !sckLevel;
    assign pauseFall  = pausePrev_reg && !pauseLevel && !quadEnableBit;
    assign pauseRise  = !pausePrev_reg && pauseLevel && !quadEnableBit;

    // Quad only counts with the lanes enabled
    assign effMode = (laneMode == LANE_QUAD && !quadEnableBit)
                     ? LANE_SINGLE : laneMode;
    assign width   = (effMode == LANE_QUAD) ? 4'h4
                   : (effMode == LANE_DUAL) ? 4'h2 : 4'h1;

    // ==========================================
    // Frame state machine
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            FRAME_IDLE:
            begin
                if (csFall)
                begin
                    state_next = FRAME_SHIFT;
                end
            end
            FRAME_SHIFT:
            begin
                if (csRise)
                begin
                    state_next = FRAME_IDLE;
                end
                else if (pauseFall && !sckLevel)
                begin
                    state_next = FRAME_PAUSE;
                end
            end
            FRAME_PAUSE:
            begin
                if (csRise)
                begin
                    state_next = FRAME_IDLE;
                end
                else if (pauseRise && !sckLevel)
                begin
                    state_next = FRAME_SHIFT;
                end
            end
            default:
            begin
                state_next = FRAME_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= FRAME_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Active shifting only when selected and not paused
    assign live    = (state_reg == FRAME_SHIFT) && !csHigh;
    assign talking = live && driveOut;

    // ==========================================
    // Receive: assemble lanes into bytes on rising edges
    assign rxTake = live && sckRise
                    && !(driveOut && effMode != LANE_SINGLE);

    always_comb
    begin
        rxShift_next = rxShift_reg;
        rxCount_next = rxCount_reg;
        unique case (effMode)
            LANE_QUAD:
            begin
                rxShift_next = {rxShift_reg[3:0], pinSync_reg[PIN_IO3],
                                pinSync_reg[PIN_IO2], pinSync_reg[PIN_IO1],
                                pinSync_reg[PIN_IO0]};
            end
            LANE_DUAL:
            begin
                rxShift_next = {rxShift_reg[5:0], pinSync_reg[PIN_IO1],
                                pinSync_reg[PIN_IO0]};
            end
            default:
            begin
                rxShift_next = {rxShift_reg[6:0], pinSync_reg[PIN_IO0]};
            end
        endcase
        rxCount_next = rxCount_reg + width;
    end

    // Receive counter survives a pause, restarts each frame
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxShift_reg <= FILL_BYTE;
            rxCount_reg <= CNT_RST;
            rxData_reg  <= FILL_BYTE;
            rxValid_reg <= 1'b0;
        end
        else
        begin
            rxValid_reg <= 1'b0;
            if (csFall)
            begin
                rxCount_reg <= CNT_RST;
            end
            else if (rxTake)
            begin
                rxShift_reg <= rxShift_next;
                if (rxCount_next >= BITS_BYTE)
                begin
                    rxCount_reg <= CNT_RST;
                    rxData_reg  <= rxShift_next;
                    rxValid_reg <= 1'b1;
                end
                else
                begin
                    rxCount_reg <= rxCount_next;
                end
            end
        end
    end

    // ==========================================
    // Transmit buffer between user and shifter
    tx_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inData   (txData),
        .inValid  (txValid),
        .inReady  (txReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // Take a new byte when the shifter runs dry at a falling edge
    assign fifoPop    = talking && sckFall && (txLeft_reg == CNT_RST);
    assign launchByte = (txLeft_reg != CNT_RST) ? txShift_reg
                      : (fifoValid ? fifoData : FILL_BYTE);

    // Launch lanes on falling edges; pause holds position
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            txShift_reg <= FILL_BYTE;
            txLeft_reg  <= CNT_RST;
            io_reg      <= 4'h0;
        end
        else if (csFall)
        begin
            txLeft_reg <= CNT_RST;
        end
        else if (talking && sckFall)
        begin
            txLeft_reg <= (txLeft_reg == CNT_RST) ? BITS_BYTE - width
                                                  : txLeft_reg - width;
            unique case (effMode)
                LANE_QUAD:
                begin
                    io_reg      <= launchByte[7:4];
                    txShift_reg <= {launchByte[3:0], 4'h0};
                end
                LANE_DUAL:
                begin
                    io_reg      <= {2'h0, launchByte[7:6]};
                    txShift_reg <= {launchByte[5:0], 2'h0};
                end
                default:
                begin
                    io_reg      <= {2'h0, launchByte[7], 1'b0};
                    txShift_reg <= {launchByte[6:0], 1'b0};
                end
            endcase
        end
    end

    // ==========================================
    // Pin drivers: float whenever deselected or paused
    assign io1Out           = io_reg[1];
    assign io0Out           = io_reg[0];
    assign quadDataLane2Out = io_reg[2];
    assign quadDataLane3Out = io_reg[3];
    assign io1Oe            = talking;
    assign io0Oe            = talking && effMode != LANE_SINGLE;
    assign quadDataLane2Oe  = talking && effMode == LANE_QUAD;
    assign quadDataLane3Oe  = talking && effMode == LANE_QUAD;

    // ==========================================
    // Frame markers, standby and protection status
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            frameStart_reg <= 1'b0;
            frameEnd_reg   <= 1'b0;
            standby_reg    <= 1'b1;
            blocked_reg    <= 1'b0;
        end
        else
        begin
            frameStart_reg <= csFall;
            frameEnd_reg   <= csRise;
            standby_reg    <= csHigh && !selfTimedBusy;
            // Open pin syncs high through the pull-up
            blocked_reg    <= !quadEnableBit && !protectModeBitHi
                              && protectModeBitLo
                              && !pinSync_reg[PIN_IO2];
        end
    end

    assign rxData             = rxData_reg;
    assign rxValid            = rxValid_reg;
    assign frameStart         = frameStart_reg;
    assign frameEnd           = frameEnd_reg;
    assign standby            = standby_reg;
    assign statusWriteBlocked = blocked_reg;
    assign pauseActive        = (state_reg == FRAME_PAUSE);
    assign frameActive        = (state_reg != FRAME_IDLE);

    // ==========================================
    // Checks
    a_frame_open: assert property (@(posedge clk) disable iff (sys_rst)
        csFall |=> frameStart_reg && state_reg == FRAME_SHIFT)
        else $error("frame did not open on chip select fall");

    a_standby_entry: assert property (@(posedge clk) disable iff (sys_rst)
        (csHigh && selfTimedBusy) |=> !standby_reg)
        else $error("standby entered during self-timed cycle");

    a_rx_capture: assert property (@(posedge clk) disable iff (sys_rst)
        rxValid_reg |-> $past(sckRise) && $past(live))
        else $error("byte completed without rising clock edge");

    a_tx_launch: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(io_reg) |-> $past(sckFall) && $past(talking))
        else $error("output changed away from falling edge");

    a_so_float: assert property (@(posedge clk) disable iff (sys_rst)
        csHigh |-> !io1Oe && !io0Oe)
        else $error("serial output driven while deselected");

    a_si_ignore: assert property (@(posedge clk) disable iff (sys_rst)
        csHigh ##1 csHigh |-> !rxValid_reg && $stable(rxShift_reg))
        else $error("input taken while deselected");

    a_dual_lanes: assert property (@(posedge clk) disable iff (sys_rst)
        io0Oe |-> io1Oe && effMode != LANE_SINGLE)
        else $error("lane zero driven outside multi-lane read");

    a_wp_block: assert property (@(posedge clk) disable iff (sys_rst)
        (!quadEnableBit && !protectModeBitHi && protectModeBitLo
         && !pinSync_reg[PIN_IO2]) |=> blocked_reg)
        else $error("status write not blocked");

    a_quad_lanes: assert property (@(posedge clk) disable iff (sys_rst)
        (quadDataLane2Oe || quadDataLane3Oe) |-> quadEnableBit)
        else $error("upper lanes driven with quad disabled");

    a_pause_entry: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == FRAME_SHIFT) ##1 (state_reg == FRAME_PAUSE)
        |-> $past(pauseFall) && !$past(sckLevel))
        else $error("pause entered without pin fall at low clock");

    a_pause_exit: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == FRAME_PAUSE) ##1 (state_reg == FRAME_SHIFT)
        |-> $past(pauseRise) && !$past(sckLevel))
        else $error("pause left without pin rise at low clock");

    a_pause_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == FRAME_PAUSE) |-> (!io1Oe && !io0Oe)
        ##1 ($stable(rxCount_reg) && $stable(txLeft_reg)))
        else $error("activity while paused");

endmodule

`default_nettype wire

// ==== sim/spi_host_model.sv ====
// Host controller model that drives the flash link pins.
// Assumes the bench clk; pins change 1 ns after a clk edge, link period 80 ns.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    // System
    input  wire logic clk,
    // Link pins
    output logic      csN,
    output logic      sck,
    output logic      io0,
    output logic      pauseN,
    input  wire logic [3:0] lanes
);
    logic [7:0] rdByte;
    event       rdDone;

    // ==========================================
    // Pin timing
    // Half a link period, launched just after a clk edge
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Frame edges; the clock idles low or high as the mode asks
    task automatic frame(input logic sel, input logic idle);
        sck = idle;
        half();
        csN = ~sel;
        repeat (2) half();
    endtask

    // Bits hi down to lo, data set while the clock is low
    task automatic put(input logic [7:0] b, input int hi, input int lo);
        for (int i = hi; i >= lo; i--)
        begin
            sck = 1'b0;
            io0 = b[i];
            half();
            sck = 1'b1;
            half();
        end
        sck = 1'b0;
        half();
    endtask

    // One byte out over w lanes, sampled late in the high time before the next fall
    task automatic get(input int w);
        io0 = 1'b0;
        for (int i = 7; i >= 0; i -= w)
        begin
            sck = 1'b0;
            half();
            sck = 1'b1;
            half();
            if (w == 4)
                rdByte[i -: 4] = lanes;
            else if (w == 2)
                rdByte[i -: 2] = lanes[1:0];
            else
                rdByte[i] = lanes[1];
        end
        -> rdDone;
    endtask

    // Pause edges only with the clock low, quad off, frame live
    task automatic pause(input logic on);
        pauseN = ~on;
        repeat (2) half();
    endtask

    // Idle pins at time zero
    initial
    begin
        csN = 1'b1;
        sck = 1'b0;
        io0 = 1'b0;
        pauseN = 1'b1;
    end
endmodule
`default_nettype wire

// ==== sim/serial_flash_pin_interface_tb_top.sv ====
// Self-checking bench for the device side of the flash pin link.
// Assumes flash_pin_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module serial_flash_pin_interface_tb_top;
    import flash_pin_pkg::*;
    logic clk, sys_rst, csN, sck, hostIo0, pauseN, wpLow, io0Pin, io1Pin, l2Pin, l3Pin;
    logic io0Out, io0Oe, io1Out, io1Oe, l2Out, l2Oe, l3Out, l3Oe, qe, hi, lo, busy;
    logic driveOut, txValid, txReady, rxValid, frameStart, frameEnd, standby;
    logic pauseActive, blocked, frameActive;
    logic [7:0] rxData, txData, v;
    laneMode_t  laneMode;
    int         failures, cmp_count, cycles;
    logic [7:0] rxQ[$], txQ[$];
    logic [3:0] opens, closes;

    // ==========================================
    // Clock, pins and instances
    always #5 clk = ~clk;
    // Released IO1 shows the inverse of its last value; protect pin pulled up
    assign io0Pin = io0Oe ? io0Out : hostIo0;
    assign io1Pin = io1Oe ? io1Out : ~io1Out;
    assign l2Pin  = l2Oe ? l2Out : ~wpLow;
    assign l3Pin  = l3Oe ? l3Out : pauseN;

    spi_host_model hostU (.clk(clk), .csN(csN), .sck(sck), .io0(hostIo0),
        .pauseN(pauseN), .lanes({l3Pin, l2Pin, io1Pin, io0Pin}));

    serial_flash_pin_interface dut_u (.clk(clk), .sys_rst(sys_rst), .csN(csN), .sck(sck),
        .io0In(io0Pin), .io0Out(io0Out), .io0Oe(io0Oe), .io1In(io1Pin), .io1Out(io1Out),
        .io1Oe(io1Oe), .quadDataLane2In(l2Pin), .quadDataLane2Out(l2Out),
        .quadDataLane2Oe(l2Oe), .quadDataLane3In(l3Pin), .quadDataLane3Out(l3Out),
        .quadDataLane3Oe(l3Oe), .quadEnableBit(qe), .protectModeBitHi(hi),
        .protectModeBitLo(lo), .selfTimedBusy(busy), .laneMode(laneMode),
        .driveOut(driveOut), .rxData(rxData), .rxValid(rxValid), .frameStart(frameStart),
        .frameEnd(frameEnd), .txData(txData), .txValid(txValid), .txReady(txReady),
        .standby(standby), .pauseActive(pauseActive), .statusWriteBlocked(blocked),
        .frameActive(frameActive));

    // ==========================================
    // Checking and closing
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic step();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Results taken against the oldest note
    always @(negedge clk)
        if (rxValid === 1'b1)
            chk(rxData, rxQ.size() ? rxQ.pop_front() : 8'hxx);
    always @(hostU.rdDone)
        chk(hostU.rdByte, txQ.size() ? txQ.pop_front() : 8'hxx);

    // Frame markers counted where they stand
    always @(negedge clk)
    begin
        if (frameStart === 1'b1)
            opens++;
        if (frameEnd === 1'b1)
            closes++;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            close_out();
        end
    end

    // ==========================================
    // Main sequence
    initial
    begin
        clk = 0; sys_rst = 1; qe = 0; hi = 0; lo = 1; busy = 0; wpLow = 0;
        driveOut = 0; txValid = 0; txData = 8'h00; laneMode = LANE_SINGLE;
        failures = 0; cmp_count = 0; cycles = 0; opens = 0; closes = 0;
        void'($urandom(16));
        repeat (10) @(posedge clk);
        #1 sys_rst = 0;
        step();
        chk({io1Oe, standby, txReady}, 8'h03);
        // Deselected traffic is dropped, then one byte is written
        hostU.put($urandom, 7, 0);
        v = $urandom;
        rxQ.push_back(v);
        hostU.frame(1, 0);
        chk({frameActive, standby}, 8'h02);
        hostU.put(v, 7, 0);
        hostU.frame(0, 0);
        $display("test write done");
        // Pause in mid-byte keeps the bit count, clocks meanwhile ignored
        v = $urandom;
        rxQ.push_back(v);
        hostU.frame(1, 0);
        hostU.put(v, 7, 4);
        hostU.pause(1);
        chk({7'h0, pauseActive}, 8'h01);
        hostU.put(~v, 7, 4);
        hostU.pause(0);
        chk({7'h0, pauseActive}, 8'h00);
        hostU.put(v, 3, 0);
        hostU.frame(0, 0);
        $display("test pause done");
        // Fill the buffer until it refuses, then read it out in mode 3
        for (int i = 0; i < TX_DEPTH; i++)
        begin
            v = $urandom;
            txQ.push_back(v);
            rxQ.push_back(8'h00);
            txData = v;
            txValid = 1;
            @(posedge clk);
            #1;
        end
        txValid = 0;
        chk({7'h0, txReady}, 8'h00);
        driveOut = 1;
        hostU.frame(1, 1);
        chk({io1Oe, io0Oe}, 8'h02);
        repeat (TX_DEPTH) hostU.get(1);
        hostU.frame(0, 1);
        chk({io1Oe, frameActive, txReady}, 8'h01);
        driveOut = 0;
        $display("test read done");
        // One byte over two lanes, then one over four, quad lanes enabled
        qe = 1;
        for (int m = 1; m <= 2; m++)
        begin
            v = $urandom;
            txQ.push_back(v);
            txData = v;
            txValid = 1;
            @(posedge clk);
            #1 txValid = 0;
            laneMode = (m == 1) ? LANE_DUAL : LANE_QUAD;
            driveOut = 1;
            hostU.frame(1, 1);
            chk({l3Oe, l2Oe, io1Oe, io0Oe}, (m == 1) ? 8'h03 : 8'h0f);
            hostU.get(2 * m);
            hostU.frame(0, 1);
            driveOut = 0;
        end
        qe = 0;
        laneMode = LANE_SINGLE;
        $display("test lanes done");
        // Protect pin against every setting of the protect and quad bits
        for (int i = 0; i < 16; i++)
        begin
            {qe, hi, lo, wpLow} = i[3:0];
            step();
            chk({7'h0, blocked}, {7'h0, !qe && !hi && lo && wpLow});
        end
        {qe, hi, lo, wpLow} = 4'h2;
        busy = 1;
        step();
        chk({7'h0, standby}, 8'h00);
        busy = 0;
        step();
        chk({7'h0, standby}, 8'h01);
        $display("test status done");
        chk({opens, closes}, 8'h55);
        close_out();
    end
endmodule
`default_nettype wire
